// ### hdl/tpw_clkdiv.sv
`timescale 1ns/10ps
`default_nettype none
module tpw_clkdiv (
   input wire logic clk_i,          // system clock
   input wire logic rst_i,          // synchronous reset
   input wire logic sub_lvl_i,      // synchronised subclock level
   input wire logic [1:0] sel_i,    // count source select
   output logic tick_o              // one-cycle count clock tick
);

   logic [4:0] div_cnt;
   logic [4:0] sub_cnt;
   logic sub_prev;
   logic sub_rise;

   assign sub_rise = sub_lvl_i & ~sub_prev;

   // ----------------------------------------------------------------
   // free running prescalers for the internal and sub clocks
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= 5'h00;
         sub_cnt <= 5'h00;
         sub_prev <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 5'h01;
         sub_prev <= sub_lvl_i;
         if (sub_rise) begin
            sub_cnt <= sub_cnt + 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // pick one source and register the tick
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         case (sel_i) // [R1]
            tpw_pkg::CLK_UNDIV: tick_o <= 1'b1;
            tpw_pkg::CLK_DIV8: tick_o <= (div_cnt[2:0] == tpw_pkg::DIV8_LAST[2:0]);
            tpw_pkg::CLK_DIV32: tick_o <= (div_cnt == tpw_pkg::DIV32_LAST);
            tpw_pkg::CLK_SUB32: tick_o <= sub_rise && (sub_cnt == tpw_pkg::DIV32_LAST);
            default: tick_o <= 1'b0;
         endcase
      end
   end

endmodule // tpw_clkdiv
`default_nettype wire

// ### hdl/tpw_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tpw_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,          // system clock
   input wire logic rst_i,          // synchronous reset
   input wire logic [W-1:0] d_i,    // asynchronous levels
   output logic [W-1:0] q_o         // synchronised levels
);

   logic [W-1:0] meta;

   // ----------------------------------------------------------------
   // two-stage synchroniser, first stage read only by the second
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule // tpw_sync
`default_nettype wire

// ### hdl/tpw_top.sv
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [R1] The count clock is one of the undivided clock, clock/8, clock/32 or subclock/32, chosen by software.
// [R2] The counter counts down, either as one 16-bit modulator or as an 8-bit modulator with 8-bit prescaler.
// [R3] At every rising edge of the output the counter reloads from the reload register and keeps running.
// [R4] Once counting has begun, further triggers neither restart nor reload the counter.
// [R5] In 16-bit operation the output is high for n count periods in a fixed cycle of 2^16-1 periods.
// [R6] In 8-bit operation the output is high for n*(m+1) periods in a cycle of 255*(m+1) periods.
// [R7] Counting begins on the chosen start event: trigger pin edge, other timer overflow, or the start flag.
// [R8] The modulator stops only when software clears the start flag.
// [R9] In 8-bit operation the request comes when the output falls, or when the count reaches 01 for widths FF and 00.
// [R10] In 16-bit operation the request comes on the fall, or when the count reaches 0001 for widths FFFF and 0000.
// [R11] The output pin carries the pulse; the input pin is either a plain input or the trigger input.
// [R12] Reading the timer register gives no meaningful count.
// [R13] A timer write while stopped updates both the reload register and the counter.
// [R14] A timer write while running updates only the reload register, taken at the next reload.
// [R15] A zero high width holds the output low and loads the inverted value, all ones, into the timer.
module tpw_top (
   input wire logic clk_i,                  // system clock, 100 MHz
   input wire logic rst_i,                  // synchronous reset, active high
   input wire logic wb_cyc_i,               // wishbone cycle
   input wire logic wb_stb_i,               // wishbone strobe
   input wire logic wb_we_i,                // wishbone write enable
   input wire logic [7:0] wb_adr_i,         // wishbone byte address
   input wire logic [3:0] wb_sel_i,         // wishbone byte selects
   input wire logic [31:0] wb_dat_i,        // wishbone write data
   output logic [31:0] wb_dat_o,            // wishbone read data
   output logic wb_ack_o,                   // wishbone acknowledge
   input wire logic trigger_input_pin_i,    // external trigger / port pin
   input wire logic subclock_i,             // slow subclock, asynchronous
   input wire logic other_ovf_i,            // overflow pulse of another timer
   output logic pulse_output_pin_o,         // modulated pulse output
   output logic irq_req_o                   // one-cycle interrupt request
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   tpw_pkg::tpw_state_t state, next_state;
   logic start_flag;
   logic mode8;
   logic [1:0] clk_sel;
   logic [1:0] trig_sel;
   logic trig_fall;
   logic [15:0] reload;
   logic [15:0] cnt, next_cnt;
   logic [15:0] per_cnt, next_per;
   logic [7:0] presc, next_presc;
   logic pulse, next_pulse;
   logic spec, next_spec;
   logic next_irq;
   logic req;
   logic wr;
   logic hit_ctrl, hit_timer, hit_status;
   logic [15:0] wr_reload;
   logic trig_lvl, sub_lvl;
   logic trig_prev;
   logic trig_edge;
   logic trig_evt;
   logic tick;
   logic [15:0] load_cnt;
   logic load_pulse;
   logic load_spec;
   logic [15:0] last_step;
   logic go_pend;

   // ----------------------------------------------------------------
   // pin synchronisers and count clock
   // ----------------------------------------------------------------
   tpw_sync #(
      .W(2)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({trigger_input_pin_i, subclock_i}),
      .q_o({trig_lvl, sub_lvl})
   );

   tpw_clkdiv u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sub_lvl_i(sub_lvl),
      .sel_i(clk_sel),
      .tick_o(tick)
   );

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   // a request is served once, in the cycle before ack rises
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i;
   assign hit_ctrl = (wb_adr_i[7:2] == tpw_pkg::ADDR_CTRL[7:2]);
   assign hit_timer = (wb_adr_i[7:2] == tpw_pkg::ADDR_TIMER[7:2]);
   assign hit_status = (wb_adr_i[7:2] == tpw_pkg::ADDR_STATUS[7:2]);

   // byte lanes 0 and 1 write the low and high byte of the timer
   assign wr_reload = {wb_sel_i[1] ? wb_dat_i[15:8] : reload[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : reload[7:0]};

   // acknowledge one cycle after the request is seen, then drop it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // read data; the timer word reads as zero since no count is exposed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= 32'h0000_0000;
         if (hit_ctrl) begin
            wb_dat_o[tpw_pkg::CTRL_START_BIT] <= start_flag;
            wb_dat_o[tpw_pkg::CTRL_MODE8_BIT] <= mode8;
            wb_dat_o[tpw_pkg::CTRL_CLKSEL_LSB +: 2] <= clk_sel;
            wb_dat_o[tpw_pkg::CTRL_TRIGSEL_LSB +: 2] <= trig_sel;
            wb_dat_o[tpw_pkg::CTRL_TRIGFALL_BIT] <= trig_fall;
         end else if (hit_timer) begin
            wb_dat_o <= 32'h0000_0000; // [R12]
         end else if (hit_status) begin
            wb_dat_o[tpw_pkg::STAT_RUN_BIT] <= (state == tpw_pkg::TPW_RUN);
            wb_dat_o[tpw_pkg::STAT_PULSE_BIT] <= pulse;
            wb_dat_o[tpw_pkg::STAT_ARMED_BIT] <= (state == tpw_pkg::TPW_ARMED);
            wb_dat_o[tpw_pkg::STAT_PIN_BIT] <= trig_lvl; // [R11]
         end
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_flag <= tpw_pkg::CTRL_RESET[tpw_pkg::CTRL_START_BIT];
         mode8 <= tpw_pkg::CTRL_RESET[tpw_pkg::CTRL_MODE8_BIT];
         clk_sel <= tpw_pkg::CTRL_RESET[tpw_pkg::CTRL_CLKSEL_LSB +: 2];
         trig_sel <= tpw_pkg::CTRL_RESET[tpw_pkg::CTRL_TRIGSEL_LSB +: 2];
         trig_fall <= tpw_pkg::CTRL_RESET[tpw_pkg::CTRL_TRIGFALL_BIT];
      end else if (wr && hit_ctrl && wb_sel_i[0]) begin
         start_flag <= wb_dat_i[tpw_pkg::CTRL_START_BIT]; // [R8]
         mode8 <= wb_dat_i[tpw_pkg::CTRL_MODE8_BIT]; // [R2]
         clk_sel <= wb_dat_i[tpw_pkg::CTRL_CLKSEL_LSB +: 2]; // [R1]
         trig_sel <= wb_dat_i[tpw_pkg::CTRL_TRIGSEL_LSB +: 2];
         trig_fall <= wb_dat_i[tpw_pkg::CTRL_TRIGFALL_BIT];
      end
   end

   // reload register takes every timer write, running or not
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload <= tpw_pkg::TIMER_RESET;
      end else if (wr && hit_timer) begin
         reload <= wr_reload; // [R13] [R14]
      end
   end

   // ----------------------------------------------------------------
   // start events
   // ----------------------------------------------------------------
   // edge detection works on the synchronised level only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_prev <= 1'b0;
      end else begin
         trig_prev <= trig_lvl;
      end
   end

   assign trig_edge = trig_fall ? (trig_prev & ~trig_lvl) : (trig_lvl & ~trig_prev);

   // when the pin is not the trigger it is just a readable port bit
   always_comb begin
      case (trig_sel) // [R7] [R11]
         tpw_pkg::TRIG_PIN: trig_evt = trig_edge;
         tpw_pkg::TRIG_OVF: trig_evt = other_ovf_i;
         default: trig_evt = 1'b0;
      endcase
   end

   // a start event waits for the next count tick, so the first high
   // period is a whole one like every later one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go_pend <= 1'b0;
      end else if (state != tpw_pkg::TPW_ARMED) begin
         go_pend <= 1'b0;
      end else if (trig_evt) begin
         go_pend <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // values taken at each reload
   // ----------------------------------------------------------------
   // a zero width is loaded inverted so the counter still sweeps a cycle
   always_comb begin
      if (mode8) begin
         load_cnt = {(reload[15:8] == 8'h00) ? 8'hFF : reload[15:8], reload[7:0]}; // [R15]
         load_pulse = (reload[15:8] != 8'h00); // [R15]
         load_spec = (reload[15:8] == 8'hFF) || (reload[15:8] == 8'h00);
         last_step = tpw_pkg::CYC8_LAST; // [R6]
      end else begin
         load_cnt = (reload == 16'h0000) ? 16'hFFFF : reload; // [R15]
         load_pulse = (reload != 16'h0000); // [R15]
         load_spec = (reload == 16'hFFFF) || (reload == 16'h0000);
         last_step = tpw_pkg::CYC16_LAST; // [R5]
      end
   end

   // ----------------------------------------------------------------
   // modulator next state
   // ----------------------------------------------------------------
   // the width counter is the whole word in 16-bit mode and the high
   // byte in 8-bit mode; the low byte then counts the prescaler
   always_comb begin
      logic [15:0] w;
      logic [15:0] w_dec;
      logic step;
      w = mode8 ? {8'h00, cnt[15:8]} : cnt;
      w_dec = w - 16'h0001;
      step = 1'b0;
      next_state = state;
      next_cnt = cnt;
      next_per = per_cnt;
      next_presc = presc;
      next_pulse = pulse;
      next_spec = spec;
      next_irq = 1'b0;
      case (state)
         tpw_pkg::TPW_IDLE: begin
            next_pulse = 1'b0;
            if (wr && hit_timer) begin
               next_cnt = wr_reload; // [R13]
            end
            if (start_flag) begin
               next_state = (trig_sel == tpw_pkg::TRIG_SW) ? tpw_pkg::TPW_ARMED : tpw_pkg::TPW_ARMED;
            end
         end
         tpw_pkg::TPW_ARMED: begin
            next_pulse = 1'b0;
            if (wr && hit_timer) begin
               next_cnt = wr_reload; // [R13]
            end
            if (!start_flag) begin
               next_state = tpw_pkg::TPW_IDLE; // [R8]
            end else if ((trig_sel == tpw_pkg::TRIG_SW || trig_evt || go_pend) && tick) begin // [R5] [R6]
               next_state = tpw_pkg::TPW_RUN; // [R7]
               next_cnt = load_cnt;
               next_presc = reload[7:0];
               next_pulse = load_pulse;
               next_spec = load_spec;
               next_per = 16'h0000;
            end
         end
         tpw_pkg::TPW_RUN: begin
            // triggers are not looked at here at all
            if (!start_flag) begin // [R4]
               next_state = tpw_pkg::TPW_IDLE; // [R8]
               next_pulse = 1'b0;
            end else if (tick) begin
               if (mode8) begin
                  step = (cnt[7:0] == 8'h00); // [R6]
                  next_cnt[7:0] = step ? presc : (cnt[7:0] - 8'h01);
               end else begin
                  step = 1'b1; // [R5]
               end
               if (step) begin
                  if (per_cnt == last_step) begin
                     // new cycle: output goes high unless the width is zero, and counter reloads
                     next_cnt = load_cnt; // [R3] [R14]
                     next_presc = reload[7:0];
                     next_pulse = load_pulse;
                     next_spec = load_spec;
                     next_per = 16'h0000;
                  end else begin
                     next_per = per_cnt + 16'h0001;
                     if (mode8) begin
                        next_cnt[15:8] = w_dec[7:0]; // [R2]
                     end else begin
                        next_cnt = w_dec; // [R2]
                     end
                     if (pulse && (w == 16'h0001)) begin
                        next_pulse = 1'b0; // [R5] [R6]
                        next_irq = !spec; // [R9] [R10]
                     end
                     if (spec && (w == 16'h0002)) begin
                        next_irq = 1'b1; // [R9] [R10]
                     end
                  end
               end
            end
         end
         default: begin
            next_state = tpw_pkg::TPW_IDLE;
            next_pulse = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // modulator registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= tpw_pkg::TPW_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= tpw_pkg::TIMER_RESET;
         per_cnt <= 16'h0000;
         presc <= 8'h00;
         spec <= 1'b0;
      end else begin
         cnt <= next_cnt;
         per_cnt <= next_per;
         presc <= next_presc;
         spec <= next_spec;
      end
   end

   // pin and request come straight from flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse <= 1'b0;
         irq_req_o <= 1'b0;
      end else begin
         pulse <= next_pulse;
         irq_req_o <= next_irq;
      end
   end

   assign pulse_output_pin_o = pulse; // [R11]

endmodule // tpw_top
`default_nettype wire

// ### inc/tpw_pkg.sv
`default_nettype none
package tpw_pkg;

   // ----------------------------------------------------------------
   // bus geometry and register offsets
   // ----------------------------------------------------------------
   localparam int WB_AW = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TIMER = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_MODE8_BIT = 1;
   localparam int CTRL_CLKSEL_LSB = 2;
   localparam int CTRL_TRIGSEL_LSB = 4;
   localparam int CTRL_TRIGFALL_BIT = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   localparam logic [15:0] TIMER_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_PULSE_BIT = 1;
   localparam int STAT_ARMED_BIT = 2;
   localparam int STAT_PIN_BIT = 3;

   // ----------------------------------------------------------------
   // count source and start source encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] CLK_UNDIV = 2'h0;
   localparam logic [1:0] CLK_DIV8 = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_SUB32 = 2'h3;
   localparam logic [1:0] TRIG_SW = 2'h0;
   localparam logic [1:0] TRIG_PIN = 2'h1;
   localparam logic [1:0] TRIG_OVF = 2'h2;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam logic [4:0] DIV8_LAST = 5'h07;
   localparam logic [4:0] DIV32_LAST = 5'h1F;
   localparam logic [15:0] CYC16_LAST = 16'hFFFE;  // 2^16-1 steps, index 0..FFFE
   localparam logic [15:0] CYC8_LAST = 16'h00FE;   // 2^8-1 steps, index 0..FE

   typedef enum logic [1:0] {
      TPW_IDLE,
      TPW_ARMED,
      TPW_RUN
   } tpw_state_t;

endpackage
`default_nettype wire

// ### testbench/tpw_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// trigger source and pulse load
// ----------------------------------------------------------------
module tpw_partner (
   input wire logic clk_i,   // system clock
   input wire logic pulse_i, // pulse output pin under test
   output logic trig_o,      // trigger input pin
   output logic sub_o,       // free-running subclock
   output logic ovf_o,       // other timer overflow pulse
   output int hi_o,          // last high width in cycles
   output int per_o,         // last rise to rise in cycles
   output int rises_o        // rises seen so far
);
   int now;
   int t_rise;
   logic last;
   initial begin
      trig_o = 1'b0;
      sub_o = 1'b0;
      ovf_o = 1'b0;
      hi_o = 0;
      per_o = 0;
      rises_o = 0;
      now = 0;
      t_rise = 0;
      last = 1'b0;
   end
   // crystal runs free; 67 ns half period drifts over the clock, landing on a rising edge every tenth toggle
   always #67 sub_o = ~sub_o;
   // the load measures the pulse as the pin shows it
   always @(posedge clk_i) begin
      now <= now + 1;
      last <= pulse_i;
      if (pulse_i && !last) begin
         per_o <= now - t_rise;
         t_rise <= now;
         rises_o <= rises_o + 1;
      end
      if (!pulse_i && last) hi_o <= now - t_rise;
   end
   task automatic pin(input logic v);
      @(posedge clk_i);
      trig_o <= v;
   endtask
   task automatic ovf();
      @(posedge clk_i);
      ovf_o <= 1'b1;
      @(posedge clk_i);
      ovf_o <= 1'b0;
   endtask
endmodule // tpw_partner
`default_nettype wire

// ### testbench/tpw_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module tpw_top_assertions (
   input wire logic clk_i,              // system clock
   input wire logic rst_i,              // synchronous reset
   input wire logic wb_cyc_i,           // cycle
   input wire logic wb_stb_i,           // strobe
   input wire logic wb_we_i,            // write enable
   input wire logic [7:0] wb_adr_i,     // address
   input wire logic [3:0] wb_sel_i,     // byte selects
   input wire logic [31:0] wb_dat_i,    // write data
   input wire logic [31:0] wb_dat_o,    // read data
   input wire logic wb_ack_o,           // acknowledge
   input wire logic pulse_output_pin_o, // pulse output
   input wire logic irq_req_o           // interrupt request
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd(logic [7:0] a);
      s_req ##0 (!wb_we_i && wb_adr_i[7:2] == a[7:2]);
   endsequence
   // a taken stop write; the restart cannot land inside the next three cycles
   sequence s_stop;
      s_req ##0 (wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] && !wb_dat_i[0]);
   endsequence
   a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
      else $error("ack without request");
   a_irq_single: assert property (irq_req_o |=> !irq_req_o) else $error("irq too long");
   a_reset_quiet: assert property ($fell(rst_i) |-> !pulse_output_pin_o && !irq_req_o && !wb_ack_o)
      else $error("outputs active after reset");
   a_stop_low: assert property (s_stop |-> ##2 !pulse_output_pin_o [*3])
      else $error("pulse after stop");
   a_timer_read: assert property (s_rd(tpw_pkg::ADDR_TIMER) |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("timer read not zero");
   a_hole_read: assert property (s_rd(8'h0C) |=> wb_dat_o == 32'h0) else $error("hole read not zero");
endmodule // tpw_top_assertions
bind tpw_top tpw_top_assertions tpw_top_assertions_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pulse_output_pin_o, .irq_req_o);
`default_nettype wire

// ### testbench/tpw_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tpw_top_bench;
   localparam logic [7:0] AC = tpw_pkg::ADDR_CTRL;
   localparam logic [7:0] AT = tpw_pkg::ADDR_TIMER;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, pulse_output_pin_o, irq_req_o, trigger_input_pin_i, subclock_i, other_ovf_i;
   int hi, per, rises, i0, r0;
   int error_cnt = 0, cmp_count = 0, irq_cnt = 0;
   always #5 clk_i = ~clk_i;
   // requests are single-cycle pulses, so a plain count suffices
   always @(posedge clk_i) if (irq_req_o === 1'b1) irq_cnt <= irq_cnt + 1;
   tpw_top tpw_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .trigger_input_pin_i, .subclock_i, .other_ovf_i, .pulse_output_pin_o, .irq_req_o);
   tpw_partner tpw_partner_inst (.clk_i, .pulse_i(pulse_output_pin_o), .trig_o(trigger_input_pin_i),
      .sub_o(subclock_i), .ovf_o(other_ovf_i), .hi_o(hi), .per_o(per), .rises_o(rises));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", w, e, g);
      end
   endtask
   // classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic wait_rise(input int k);
      int r, n;
      r = rises;
      n = 0;
      while (rises < r + k && n < 70000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 70000) begin
         error_cnt++;
         stop_test();
      end
   endtask
   // extra edges let the load's figure and the request land
   task automatic wait_low();
      int n;
      n = 0;
      while (pulse_output_pin_o !== 1'b0 && n < 70000) begin
         @(posedge clk_i);
         n++;
      end
      repeat (3) @(posedge clk_i);
      if (n >= 70000) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic halt();
      wb(1'b1, AC, 32'h0);
      repeat (3) @(posedge clk_i);
      chk("stopped pin", 1'b0, pulse_output_pin_o);
      wb(1'b0, tpw_pkg::ADDR_STATUS, 32'h0);
      chk("run bit", 1'b0, rd[tpw_pkg::STAT_RUN_BIT]);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_regs();
      wb(1'b0, AC, 32'h0);
      chk("ctrl", 32'h0, rd);
      wb(1'b0, AT, 32'h0);
      chk("timer", 32'h0, rd);
      wb(1'b0, 8'h0C, 32'h0);
      chk("hole", 32'h0, rd);
   endtask
   task automatic s_pwm16();
      i0 = irq_cnt;
      wb(1'b1, AT, 32'h3);
      wb(1'b1, AC, 32'h1);
      wait_rise(1);
      wb(1'b1, AT, 32'h5);
      wait_low();
      chk("width16", 3, hi);
      chk("irq16", i0 + 1, irq_cnt);
      wait_rise(1);
      chk("cycle16", 65535, per);
      wait_low();
      chk("reloaded", 5, hi);
      halt();
   endtask
   task automatic s_pwm8();
      wb(1'b1, AT, 32'h0201);
      wb(1'b1, AC, 32'h3);
      wait_rise(1);
      i0 = irq_cnt;
      wait_low();
      chk("width8", 4, hi);
      chk("irq8", i0 + 1, irq_cnt);
      wait_rise(1);
      chk("cycle8", 510, per);
      halt();
   endtask
   task automatic s_clksel();
      int lo[3] = '{8, 32, 424};
      int hh[3] = '{8, 32, 434};
      for (int s = 1; s < 4; s++) begin
         wb(1'b1, AT, 32'h1);
         wb(1'b1, AC, 32'(s << tpw_pkg::CTRL_CLKSEL_LSB) | 32'h1);
         wait_rise(1);
         wait_low();
         chk("tick width", 1'b1, hi >= lo[s-1] && hi <= hh[s-1]);
         halt();
      end
   endtask
   task automatic s_trig();
      r0 = rises;
      wb(1'b1, AT, 32'h10);
      wb(1'b1, AC, 32'h11);
      repeat (10) @(posedge clk_i);
      chk("armed rises", r0, rises);
      tpw_partner_inst.pin(1'b1);
      wait_rise(1);
      tpw_partner_inst.pin(1'b0);
      tpw_partner_inst.pin(1'b1);
      wait_low();
      chk("trig width", 16, hi);
      halt();
      r0 = rises;
      wb(1'b1, AC, 32'h21);
      repeat (5) @(posedge clk_i);
      chk("ovf armed", r0, rises);
      tpw_partner_inst.ovf();
      wait_rise(1);
      halt();
      wb(1'b1, AC, 32'h51);
      tpw_partner_inst.pin(1'b0);
      wait_rise(1);
      halt();
   endtask
   task automatic s_zero();
      r0 = rises;
      i0 = irq_cnt;
      wb(1'b1, AT, 32'h0);
      wb(1'b1, AC, 32'h3);
      repeat (600) @(posedge clk_i);
      chk("zero rises", r0, rises);
      chk("zero irq", i0 + 2, irq_cnt);
      halt();
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      s_regs();
      s_pwm16();
      s_pwm8();
      s_clksel();
      s_trig();
      s_zero();
      stop_test();
   end
endmodule // tpw_top_bench
`default_nettype wire
